// ---- core/dram_bus_glue.sv ----
// Processor-side glue: request latches, write pulse forming and byte steering.
`timescale 1ns/1ps
module dram_bus_glue
    import dram_req_pkg::*;
(
    // Clock and reset.
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // Processor side.
    input  wire logic read_req_i,
    input  wire logic write_req_i,
    input  wire logic chip_sel_i,
    input  wire logic cpu_status_one_i,
    input  wire logic addr_latch_en_i,
    input  wire logic mem_read_cmd_n_i,
    input  wire logic mem_write_cmd_n_i,
    input  wire logic advanced_mem_write_cmd_n_i,
    input  wire logic addr_bit0_i,
    input  wire logic upper_byte_enable_n_i,
    // Controller side.
    dram_req_if.glue  bus,
    // Ready and memory write pulses.
    output logic      cpu_ready_o,
    output logic      low_write_n_o,
    output logic      high_write_n_o
);

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] mrd_s_r, mwr_s_r, amw_s_r, transfer_ack_n_s_r, we_s_r;
    always_ff @(posedge ref_clk_i) begin
        mrd_s_r  <= {mrd_s_r[0], mem_read_cmd_n_i};
        mwr_s_r  <= {mwr_s_r[0], mem_write_cmd_n_i};
        amw_s_r  <= {amw_s_r[0], advanced_mem_write_cmd_n_i};
        transfer_ack_n_s_r <= {transfer_ack_n_s_r[0], bus.transfer_ack_n};
        we_s_r   <= {we_s_r[0], bus.write_enable_n};
    end

    logic mrd_d_r, mwr_d_r, ale_d_r, rd_lat_r, wr_lat_r;
    logic cmd_end;
    assign cmd_end = (!mrd_d_r && mrd_s_r[1]) || (!mwr_d_r && mwr_s_r[1]);

    // only one request latch is set at a time
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            mrd_d_r  <= 1'b1;
            mwr_d_r  <= 1'b1;
            ale_d_r  <= 1'b0;
            rd_lat_r <= 1'b0;
            wr_lat_r <= 1'b0;
        end else begin
            mrd_d_r <= mrd_s_r[1];
            mwr_d_r <= mwr_s_r[1];
            ale_d_r <= addr_latch_en_i;
            // A new latch strobe wins over the end of the previous command.
            if (ale_d_r && !addr_latch_en_i) begin
                rd_lat_r <= read_req_i;
                wr_lat_r <= write_req_i && !read_req_i;
            end else if (cmd_end) begin
                rd_lat_r <= 1'b0;
                wr_lat_r <= 1'b0;
            end
        end
    end

    // ready from transfer ack; write pulse
    logic rdy_r, lo_n_r, hi_n_r, amw_clk_n_r;
    logic pulse;
    assign pulse = !amw_clk_n_r && !we_s_r[1];
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rdy_r       <= 1'b0;
            amw_clk_n_r <= 1'b1;
            lo_n_r      <= 1'b1;
            hi_n_r      <= 1'b1;
        end else begin
            rdy_r       <= !transfer_ack_n_s_r[1];
            amw_clk_n_r <= amw_s_r[1];
            lo_n_r      <= !(pulse && !addr_bit0_i);
            hi_n_r      <= !(pulse && !upper_byte_enable_n_i);
        end
    end

    assign bus.early_read_cmd_n   = !rd_lat_r;
    assign bus.early_write_cmd_n  = !wr_lat_r;
    assign bus.protected_select_n = !chip_sel_i;
    assign bus.cpu_status_one     = cpu_status_one_i;
    assign bus.addr_latch_en      = addr_latch_en_i;
    assign cpu_ready_o            = rdy_r;
    assign low_write_n_o          = lo_n_r;
    assign high_write_n_o         = hi_n_r;

endmodule

// ---- core/dram_cycle_ctrl.sv ----
// DRAM controller end: request acceptance, acknowledges, strobes and refresh.
//
// Notes on behaviour
// - Strap selects normal or advanced read requests.
// - Read request held until transfer acknowledge.
// - Requester may drop read after hold time.
// - Advanced read is latch strobe with status.
// - Latch strobe ignored while status low.
// - Advanced read starts at latch strobe fall.
// - Read during refresh sets delayed-ack latch.
// - Delayed latch holds system ack until transfer.
// - Delayed latch cleared after each read.
// - Ready normally derived from transfer acknowledge.
// - Early system ack: use transfer or delayed.
// - Write enable active only in writes.
// - Write enable asserted before column strobe.
// - Glue clears request latches at command end.
// - Write pulse from clocked command and enable.
// - Byte write steering by address and enable.
// - System ack starts access, transfer marks data.
// - Requests need chip select; cycles complete anyway.
// - Refresh drives all rows, others inactive.
`timescale 1ns/1ps
module dram_cycle_ctrl
    import dram_req_pkg::*;
#(
    parameter int unsigned BANKS = ROW_BANKS
) (
    // Clock and reset.
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    // Bus side.
    dram_req_if.ctrl              bus,
    // Configuration and refresh.
    input  wire logic             read_mode_strap_i,
    input  wire logic             refresh_req_i,
    input  wire logic             bank_sel_i,
    // Memory array strobes.
    output logic [BANKS-1:0]      row_strobe_n_o,
    output logic                  col_strobe_n_o,
    output logic                  refresh_busy_o
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers; all bus inputs come from another clock domain.
    logic [1:0] rd_s_r, wr_s_r, cs_s_r, st_s_r, ale_s_r, ref_s_r, strap_s_r;
    logic [1:0] bank_s_r;
    logic       ale_d_r;
    always_ff @(posedge ref_clk_i) begin
        rd_s_r    <= {rd_s_r[0], bus.early_read_cmd_n};
        wr_s_r    <= {wr_s_r[0], bus.early_write_cmd_n};
        cs_s_r    <= {cs_s_r[0], bus.protected_select_n};
        st_s_r    <= {st_s_r[0], bus.cpu_status_one};
        ale_s_r   <= {ale_s_r[0], bus.addr_latch_en};
        ref_s_r   <= {ref_s_r[0], refresh_req_i};
        strap_s_r <= {strap_s_r[0], read_mode_strap_i};
        bank_s_r  <= {bank_s_r[0], bank_sel_i};
        ale_d_r   <= ale_s_r[1];
    end

    // strap capture
    // The strap is static, so it is caught once after reset release.
    logic strap_r;
    logic strap_done_r;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            strap_r      <= STRAP_NORMAL;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_r      <= strap_s_r[1];
            strap_done_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request decode.
    logic selected;
    logic adv_pulse;
    logic rd_req;
    logic wr_req;
    assign selected  = !cs_s_r[1];
    // latch strobe fall with status high
    assign adv_pulse = ale_d_r && !ale_s_r[1] && st_s_r[1];
    // level read request in normal mode
    assign rd_req    = selected && ((strap_r == STRAP_ADVANCED) ? adv_pulse : !rd_s_r[1]);
    // writes use the normal sequence in either mode
    assign wr_req    = selected && !wr_s_r[1];

    // Advanced reads are pulses; one is held pending across refresh.
    logic adv_pend_r;
    ctrl_state_t state_r;
    logic [CNT_W-1:0] cnt_r;
    logic is_write_r;
    logic delay_ack_r;
    logic req_any;
    assign req_any = rd_req || wr_req || adv_pend_r;

    ////////////////////////////////////////////////////////////////////////
    // Cycle sequencer. Refresh wins only when idle and no request waits.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_r    <= ST_IDLE;
            cnt_r      <= '0;
            is_write_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    cnt_r <= '0;
                    if (req_any) begin
                        state_r    <= ST_ROW;
                        is_write_r <= wr_req && !rd_req && !adv_pend_r;
                    end else if (ref_s_r[1]) begin
                        state_r <= ST_REFRESH;
                    end
                end
                ST_ROW: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_W'(ROW_CYCLES - 1)) begin
                        cnt_r   <= '0;
                        state_r <= ST_WE_LEAD;
                    end
                end
                ST_WE_LEAD: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_W'(WE_LEAD_CYCLES - 1)) begin
                        cnt_r   <= '0;
                        state_r <= ST_COL;
                    end
                end
                ST_COL: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_W'(COL_CYCLES - 1)) begin
                        cnt_r   <= '0;
                        state_r <= ST_DONE;
                    end
                end
                // Wait for the requester to drop its level request.
                ST_DONE: begin
                    if (is_write_r ? wr_s_r[1] : (strap_r == STRAP_ADVANCED || rd_s_r[1])) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_REFRESH: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_W'(REF_CYCLES - 1)) begin
                        cnt_r   <= '0;
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Pending advanced read across a refresh.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            adv_pend_r <= 1'b0;
        end else if (strap_r == STRAP_ADVANCED && rd_req && state_r != ST_IDLE) begin
            adv_pend_r <= 1'b1;
        end else if (state_r == ST_IDLE && adv_pend_r) begin
            adv_pend_r <= 1'b0;
        end
    end

    // Delayed-acknowledge latch; the set wins over the clear.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            delay_ack_r <= 1'b0;
        end else if (rd_req && state_r == ST_REFRESH) begin
            delay_ack_r <= 1'b1;
        end else if (state_r == ST_DONE && !is_write_r) begin
            delay_ack_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe and acknowledge outputs, all registered.
    logic active;
    logic in_col;
    assign active = state_r inside {ST_ROW, ST_WE_LEAD, ST_COL};
    assign in_col = state_r == ST_COL;

    logic system_ack_n_n_r, transfer_ack_n_n_r, we_n_r, cas_n_r, busy_r;
    logic [BANKS-1:0] ras_n_r;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            system_ack_n_n_r <= 1'b1;
            transfer_ack_n_n_r <= 1'b1;
            we_n_r   <= 1'b1;
            cas_n_r  <= 1'b1;
            ras_n_r  <= '1;
            busy_r   <= 1'b0;
        end else begin
            // system ack at start or with transfer
            system_ack_n_n_r <= !(active && (!delay_ack_r || in_col)) || is_write_r && !active;
            transfer_ack_n_n_r <= !in_col;
            // write enable from row phase of writes
            we_n_r   <= !(is_write_r && active);
            cas_n_r  <= !in_col;
            busy_r   <= state_r == ST_REFRESH;
            for (int b = 0; b < BANKS; b++) begin
                ras_n_r[b] <= !((state_r == ST_REFRESH) ||
                                (active && (BANKS == 1 || int'(bank_s_r[1]) == b)));
            end
        end
    end

    assign bus.system_ack_n   = system_ack_n_n_r;
    assign bus.transfer_ack_n = transfer_ack_n_n_r;
    assign bus.write_enable_n = we_n_r;
    assign row_strobe_n_o     = ras_n_r;
    assign col_strobe_n_o     = cas_n_r;
    assign refresh_busy_o     = busy_r;

endmodule

// ---- pkg/dram_req_if.sv ----
// Interface joining the DRAM controller and the processor bus glue.
`timescale 1ns/1ps
interface dram_req_if;
    logic early_read_cmd_n;
    logic early_write_cmd_n;
    logic protected_select_n;
    logic cpu_status_one;
    logic addr_latch_en;
    logic system_ack_n;
    logic transfer_ack_n;
    logic write_enable_n;

    modport ctrl (
        input  early_read_cmd_n, early_write_cmd_n, protected_select_n,
        input  cpu_status_one, addr_latch_en,
        output system_ack_n, transfer_ack_n, write_enable_n
    );
    modport glue (
        output early_read_cmd_n, early_write_cmd_n, protected_select_n,
        output cpu_status_one, addr_latch_en,
        input  system_ack_n, transfer_ack_n, write_enable_n
    );
endinterface

// ---- pkg/dram_req_pkg.sv ----
// Shared constants and types for the DRAM cycle request controller and its bus glue.
package dram_req_pkg;
    // Cycle timing in reference clocks.
    localparam int unsigned CLK_PERIOD_NS   = 25;
    localparam int unsigned ROW_TIME_NS     = 50;
    localparam int unsigned WE_LEAD_NS      = 25;
    localparam int unsigned COL_TIME_NS     = 100;
    localparam int unsigned REFRESH_TIME_NS = 200;
    localparam int unsigned ROW_CYCLES      = (ROW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WE_LEAD_CYCLES  = (WE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned COL_CYCLES      = (COL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned REF_CYCLES      = (REFRESH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W           = 4;
    localparam int unsigned ROW_BANKS       = 2;
    localparam logic        STRAP_NORMAL    = 1'b0;
    localparam logic        STRAP_ADVANCED  = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ROW     = 3'b001,
        ST_WE_LEAD = 3'b010,
        ST_COL     = 3'b011,
        ST_DONE    = 3'b100,
        ST_REFRESH = 3'b101
    } ctrl_state_t;
endpackage

// ---- tb/dram_cycle_request_control_test.sv ----
// Self-checking bench for the controller and glue joined through the request interface.
`timescale 1ns/1ps
module dram_cycle_request_control_test;
    import dram_req_pkg::*;

    logic                 ref_clk_i = 1'b0;
    logic                 rst_n_i   = 1'b0;
    logic                 read_req, write_req, chip_sel, status_one, latch_en;
    logic                 mem_rd_n, mem_wr_n, adv_wr_n, addr_bit0, upper_n;
    logic                 strap, refresh_req, bank_sel;
    logic [ROW_BANKS-1:0] row_n;
    logic                 col_n, ref_busy, ready, low_wr_n, high_wr_n;
    logic                 system_ack_n_early, transfer_ack_n_seen, we_seen, lo_seen, hi_seen, rdy_seen;
    int                   err_total = 0;
    int                   cmp_count = 0;
    int                   seed      = 32'h73F8;
    logic [31:0]          r;

    always #12.5 ref_clk_i = ~ref_clk_i;

    ////////////////////////////////////////////////////////////////////////////////
    dram_req_if bus_if();
    dram_cycle_ctrl dram_cycle_ctrl_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus(bus_if),
        .read_mode_strap_i(strap), .refresh_req_i(refresh_req), .bank_sel_i(bank_sel),
        .row_strobe_n_o(row_n), .col_strobe_n_o(col_n), .refresh_busy_o(ref_busy));
    dram_bus_glue dram_bus_glue_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .read_req_i(read_req), .write_req_i(write_req), .chip_sel_i(chip_sel),
        .cpu_status_one_i(status_one), .addr_latch_en_i(latch_en), .mem_read_cmd_n_i(mem_rd_n),
        .mem_write_cmd_n_i(mem_wr_n), .advanced_mem_write_cmd_n_i(adv_wr_n),
        .addr_bit0_i(addr_bit0), .upper_byte_enable_n_i(upper_n), .bus(bus_if),
        .cpu_ready_o(ready), .low_write_n_o(low_wr_n), .high_write_n_o(high_wr_n));
    dram_req_checker dram_req_checker_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .early_read_cmd_n(bus_if.early_read_cmd_n), .early_write_cmd_n(bus_if.early_write_cmd_n),
        .protected_select_n(bus_if.protected_select_n), .cpu_status_one(bus_if.cpu_status_one),
        .addr_latch_en(bus_if.addr_latch_en), .system_ack_n(bus_if.system_ack_n),
        .transfer_ack_n(bus_if.transfer_ack_n), .write_enable_n(bus_if.write_enable_n));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t: got %b expected %b", $time, got, exp);
        end
    endtask

    // A cycle needs chip select; advanced reads need status, writes use the level.
    function automatic logic cycle_expected(input logic rd, wr, cs, st, adv);
        return cs && (adv ? (wr || st) : (rd || wr));
    endfunction

    // Only the selected bank's row strobe is low during an access.
    function automatic logic [ROW_BANKS-1:0] rows_expected(input logic sel);
        return ~(ROW_BANKS'(1'b1) << sel);
    endfunction

    // Inputs change and outputs are sampled only at the falling edge.
    task automatic tick();
        @(negedge ref_clk_i);
        system_ack_n_early |= (bus_if.system_ack_n === 1'b0) && (bus_if.transfer_ack_n === 1'b1);
        transfer_ack_n_seen  |= (bus_if.transfer_ack_n === 1'b0);
        we_seen    |= (bus_if.write_enable_n === 1'b0) && (col_n === 1'b1);
        lo_seen    |= (low_wr_n === 1'b0);
        hi_seen    |= (high_wr_n === 1'b0);
        rdy_seen   |= (ready === 1'b1);
    endtask

    task automatic do_reset(input logic s);
        strap   = s;
        rst_n_i = 1'b0;
        repeat (6) tick();
        rst_n_i = 1'b1;
        repeat (3) tick();
    endtask

    task automatic run_cycle(input logic rd, wr, cs, st, adv, drop, delayed);
        logic exp;
        int   n;
        exp = cycle_expected(rd, wr, cs, st, adv);
        {system_ack_n_early, transfer_ack_n_seen, we_seen, lo_seen, hi_seen, rdy_seen} = '0;
        {read_req, write_req, chip_sel, status_one, latch_en} = {rd, wr, cs, st, 1'b1};
        tick();
        latch_en = 1'b0;
        {mem_rd_n, mem_wr_n, adv_wr_n} = {!(rd || (adv && st)), !wr, !wr};
        n = 0;
        while (!transfer_ack_n_seen && n < 40) begin
            tick();
            n++;
            if (drop && n == 5) begin
                {chip_sel, mem_rd_n} = 2'b01;
            end
        end
        check_bit(row_n === rows_expected(bank_sel), exp);
        repeat (4) tick();
        {mem_rd_n, mem_wr_n, adv_wr_n, read_req, write_req, chip_sel} = 6'h38;
        repeat (10) tick();
        check_bit(transfer_ack_n_seen, exp);
        if (exp) begin
            check_bit(system_ack_n_early, !delayed);
            check_bit(we_seen, wr);
            check_bit(lo_seen, wr && !addr_bit0);
            check_bit(hi_seen, wr && !upper_n);
            check_bit(rdy_seen, 1'b1);
        end
    endtask

    task automatic refresh_then_read();
        int n;
        refresh_req = 1'b1;
        n = 0;
        while (ref_busy !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        refresh_req = 1'b0;
        tick();
        check_bit(row_n === '0 && col_n === 1'b1 && bus_if.write_enable_n === 1'b1
            && bus_if.system_ack_n === 1'b1 && bus_if.transfer_ack_n === 1'b1, 1'b1);
        run_cycle(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        run_cycle(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {read_req, write_req, chip_sel, status_one, latch_en, addr_bit0} = '0;
        {refresh_req, bank_sel, strap} = '0;
        {mem_rd_n, mem_wr_n, adv_wr_n, upper_n} = 4'hF;
        do_reset(STRAP_NORMAL);
        run_cycle(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        run_cycle(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        run_cycle(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        run_cycle(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        refresh_then_read();
        repeat (20) begin
            r = $random(seed);
            {addr_bit0, upper_n, bank_sel} = r[5:3];
            run_cycle(r[0], !r[0] && r[1], r[2] | r[6], r[7], 1'b0, 1'b0, 1'b0);
        end
        do_reset(STRAP_ADVANCED);
        run_cycle(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        run_cycle(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        run_cycle(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        stop_test();
    end

    // The whole sequence needs under 2000 cycles; this limit of 20000 cycles leaves wide margin.
    initial begin
        #(25 * 20000);
        err_total++;
        stop_test();
    end
endmodule

// ---- tb/dram_req_checker.sv ----
// Concurrent checks on the signals between the controller and the bus glue.
`timescale 1ns/1ps
module dram_req_checker (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Requests from the glue.
    input wire logic early_read_cmd_n,
    input wire logic early_write_cmd_n,
    input wire logic protected_select_n,
    input wire logic cpu_status_one,
    input wire logic addr_latch_en,
    // Answers from the controller.
    input wire logic system_ack_n,
    input wire logic transfer_ack_n,
    input wire logic write_enable_n
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////////////////////////////////////////////
    logic [5:0] sel_idle_r;

    // A delayed acknowledge may come long after the select, so the bound is generous.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !protected_select_n) begin
            sel_idle_r <= 6'h00;
        end else if (sel_idle_r != 6'h3F) begin
            sel_idle_r <= sel_idle_r + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    transfer_ack_n_width_a: assert property ($fell(transfer_ack_n) |-> (!transfer_ack_n)[*4] ##1 transfer_ack_n)
        else $error("transfer ack width wrong");
    ack_overlap_a: assert property (!transfer_ack_n |-> !system_ack_n)
        else $error("transfer ack without system ack");
    system_ack_n_leads_a: assert property ($fell(system_ack_n) |-> ##[0:10] !transfer_ack_n)
        else $error("system ack not followed by transfer ack");
    we_write_only_a: assert property ($fell(write_enable_n) |-> !early_write_cmd_n)
        else $error("write enable without write request");
    we_early_a: assert property ($fell(transfer_ack_n) |-> write_enable_n == $past(write_enable_n, 2))
        else $error("write enable late for column phase");
    we_steady_a: assert property (!transfer_ack_n && !$past(transfer_ack_n) |-> $stable(write_enable_n))
        else $error("write enable moved during transfer");
    select_gate_a: assert property ($fell(system_ack_n) |-> sel_idle_r < 6'h28)
        else $error("cycle started without chip select");
    transfer_ack_n_gap_a: assert property ($rose(transfer_ack_n) |=> transfer_ack_n[*4])
        else $error("transfer ack returned too soon");
endmodule
